//--- include/smd_pkg.sv
// Purpose: shared constants and types for the mode register decoder
// Assumes: one system clock; command pins come from logic on that clock
// Notes: register contents have no documented reset value, zero is used

package smd_pkg;

  localparam int AW = 13;

  // command codes on {ras_n, cas_n, we_n} while cs_n is low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;

  // bank codes that pick the mode register
  localparam logic [2:0] BA_BURST = 3'h0;
  localparam logic [2:0] BA_DLL = 3'h1;

  // burst register field positions
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_EXT_BIT = 2;
  localparam int CL_LSB = 4;
  localparam int TM_BIT = 7;
  localparam int DLLRST_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int PPD_BIT = 12;

  // dll and termination register field positions
  localparam int DLLDIS_BIT = 0;
  localparam int DIC0_BIT = 1;
  localparam int DIC1_BIT = 5;
  localparam int RTT0_BIT = 2;
  localparam int RTT1_BIT = 6;
  localparam int RTT2_BIT = 9;
  localparam int AL_LSB = 3;
  localparam int WLEV_BIT = 7;
  localparam int QOFF_BIT = 12;

  // chop select that rides with a read or write command
  localparam int OTF_BIT = 12;

  // burst length modes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // latency and recovery figures
  localparam logic [4:0] CL_BASE = 5'h4;
  localparam logic [4:0] CL_EXT = 5'h8;
  localparam logic [5:0] WR_PULL_IN = 6'h2;
  localparam logic [2:0] LAST_BEAT = 3'h7;
  localparam logic [4:0] WR_CYC [8] = '{5'h10, 5'h05, 5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E};
  localparam logic [AW-1:0] MR_RESET = 13'h0000;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_BURST = 2'b11
  } smd_rd_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [AW-1:0] addr;
  } smd_cmd_t;

  typedef struct packed {
    logic [1:0] burst_mode;
    logic interleave;
    logic [4:0] cas_lat;
    logic test_mode;
    logic [4:0] wr_rec;
    logic fast_exit;
    logic dll_disable;
    logic [1:0] drv_imp;
    logic [2:0] rtt_nom;
    logic [4:0] add_lat;
    logic wlevel;
    logic out_disable;
  } smd_cfg_t;

  typedef struct packed {
    logic [2:0] col;
    logic [2:0] idx;
    logic chop;
    logic drive_n;
  } smd_beat_t;

  typedef struct packed {
    logic [AW-1:0] mr0;
    logic [AW-1:0] mr1;
    smd_cfg_t cfg;
    logic [5:0] rl;
    logic [5:0] wl;
    logic [5:0] dal;
    logic dll_on;
    logic dll_reset;
    logic pd_exit_slow;
    logic dll_for_write;
    logic wr_term_on;
    smd_rd_state_t rd_st;
    logic [5:0] rd_cnt;
    logic [2:0] rd_start;
    logic [2:0] rd_beat;
    logic rd_chop;
    logic wr_busy;
    logic [5:0] wr_cnt;
    logic wr_start;
    logic wr_chop;
    smd_beat_t [1:0] buf_q;
    logic [1:0] buf_cnt;
    logic out_valid;
  } smd_st_t;

  localparam smd_st_t ST_RESET = '0;

endpackage

//--- hw/smd_mode_decode.sv
// Purpose: decode the burst and dll mode registers and apply them to reads and writes
// Assumes: command pins are driven by logic on clk_sys; one read and one write in flight
// Notes: a read or write taken while its engine is busy is dropped
// Summary of operation
// R1 - fixed chop write starts two clocks early
// R2 - on-the-fly chop write starts like eight
// R3 - low column bits pick first burst word
// R4 - chopped read: unused four beats undriven
// R5 - read latency from cas field plus additive
// R6 - controller keeps test mode bit zero
// R7 - dll reset bit clears itself after use
// R8 - controller waits lock time after dll reset
// R9 - write recovery plus precharge gives autoprecharge delay
// R10 - controller programs recovery at least minimum
// R11 - slow exit freezes dll in power down
// R12 - fast exit keeps dll running there
// R13 - bank code one selects dll register
// R14 - controller zeroes reserved dll register bits
// R15 - write leveling limits allowed termination values; the controller sends the code unchecked
// R16 - self refresh stops and restarts the dll
// R17 - writes need dll only with write termination
// R18 - dll off: nominal termination kept zero
// R19 - dll off: write termination programmed zero
// R20 - driver impedance from two dll register bits
// R21 - write termination applies without nominal termination
// R22 - commands held additive latency; write latency sum
// R23 - additive field: zero, cl-1, cl-2, reserved
// R24 - dll disable bit turns dll off
// R25 - output disable bit floats data drivers
// R26 - burst length and order from burst register
// R27 - mode register set captures whole address
`timescale 1ns/1ps

module smd_mode_decode
  import smd_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  // command pins from the controller
  input wire smd_cmd_t cmd,
  // device state and figures from neighbouring logic
  input wire logic self_refresh,
  input wire logic pd_precharge,
  input wire logic write_odt_en,
  input wire logic [4:0] write_col_lat,
  input wire logic [4:0] trp_cyc,
  // read beat stream
  output logic beat_valid,
  output smd_beat_t beat,
  input wire logic beat_ready,
  // internal write start
  output logic wr_start,
  output logic wr_chop,
  output logic wr_term_on,
  // decoded settings
  output smd_cfg_t cfg,
  output logic [5:0] read_lat,
  output logic [5:0] write_lat,
  output logic [5:0] dal_cyc,
  output logic dll_on,
  output logic dll_reset,
  output logic pd_exit_slow,
  output logic dll_for_write
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic cmd_is(smd_cmd_t c, logic [2:0] code);
    return !c.cs_n && ({c.ras_n, c.cas_n, c.we_n} == code);
  endfunction

  // cas field is split: three low-order bits plus an extension bit
  function automatic logic [4:0] cas_of(logic [AW-1:0] m);
    return CL_BASE + {2'h0, m[CL_LSB+2:CL_LSB]} + (m[CL_EXT_BIT] ? CL_EXT : 5'h00);
  endfunction

  // reserved code reads as zero so latency stays defined
  function automatic logic [4:0] al_of(logic [1:0] f, logic [4:0] cl);
    unique case (f)
      2'h1: return cl - 5'h01; // [R23]
      2'h2: return cl - 5'h02; // [R23]
      2'h0: return 5'h00;
      2'h3: return 5'h00;
    endcase
  endfunction

  // sequential wraps inside the start nibble for four beats, then the other nibble; interleaved is xor
  function automatic logic [2:0] col_of(logic [2:0] s, logic [2:0] i, logic il);
    return il ? (s ^ i) : {s[2] ^ i[2], s[1:0] + i[1:0]}; // [R3]
  endfunction

  function automatic smd_cfg_t decode(logic [AW-1:0] m0, logic [AW-1:0] m1);
    smd_cfg_t c;
    c = '0;
    c.burst_mode = m0[BL_LSB+1:BL_LSB]; // [R26]
    c.interleave = m0[BT_BIT]; // [R26]
    c.cas_lat = cas_of(m0); // [R5]
    c.test_mode = m0[TM_BIT];
    c.wr_rec = WR_CYC[m0[WR_LSB+2:WR_LSB]]; // [R9]
    c.fast_exit = m0[PPD_BIT];
    c.dll_disable = m1[DLLDIS_BIT];
    c.drv_imp = {m1[DIC1_BIT], m1[DIC0_BIT]}; // [R20]
    c.rtt_nom = {m1[RTT2_BIT], m1[RTT1_BIT], m1[RTT0_BIT]};
    c.add_lat = al_of(m1[AL_LSB+1:AL_LSB], c.cas_lat); // [R23]
    c.wlevel = m1[WLEV_BIT];
    c.out_disable = m1[QOFF_BIT];
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  smd_st_t st;
  smd_st_t next_st;
  logic is_mrs;
  logic is_read;
  logic is_write;
  logic pop;
  logic push;
  smd_beat_t new_beat;

  assign is_mrs = cmd_is(cmd, CMD_MRS);
  assign is_read = cmd_is(cmd, CMD_READ);
  assign is_write = cmd_is(cmd, CMD_WRITE);

  // buffer handshake: a full buffer with no pop stalls the burst engine
  // limitation: clk_en low also freezes the pop, so a consumer that still
  // takes beats while the enable is low would see the head beat twice
  assign pop = st.out_valid && beat_ready;
  assign push = (st.rd_st == RD_BURST) && ((st.buf_cnt != 2'h2) || pop);

  // beats past the fourth of a chop, or all with outputs off, are undriven
  always_comb begin
    new_beat.col = col_of(st.rd_start, st.rd_beat, st.cfg.interleave); // [R3]
    new_beat.idx = st.rd_beat;
    new_beat.chop = st.rd_chop;
    new_beat.drive_n = (st.rd_chop && st.rd_beat[2]) || st.cfg.out_disable; // [R4] [R25]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [1:0] cnt;
    logic [5:0] wl_eff;
    cnt = st.buf_cnt;
    wl_eff = 6'h00;
    next_st = st;
    next_st.wr_start = 1'b0;
    next_st.wr_term_on = 1'b0;
    // mode register set loads every address bit of the chosen register
    if (is_mrs && cmd.ba == BA_BURST) begin
      next_st.mr0 = cmd.addr; // [R27]
    end else if (is_mrs && cmd.ba == BA_DLL) begin
      next_st.mr1 = cmd.addr; // [R13] [R27]
    end
    // dll reset is one pulse, then the stored bit falls back to zero
    next_st.dll_reset = st.mr0[DLLRST_BIT]; // [R7]
    if (st.mr0[DLLRST_BIT] && !(is_mrs && cmd.ba == BA_BURST)) begin
      next_st.mr0[DLLRST_BIT] = 1'b0; // [R7]
    end
    // decode from the values being stored so settings land with them
    next_st.cfg = decode(next_st.mr0, next_st.mr1);
    next_st.rl = {1'b0, next_st.cfg.add_lat} + {1'b0, next_st.cfg.cas_lat}; // [R5]
    next_st.wl = {1'b0, next_st.cfg.add_lat} + {1'b0, write_col_lat}; // [R22]
    next_st.dal = {1'b0, next_st.cfg.wr_rec} + {1'b0, trp_cyc}; // [R9]
    next_st.pd_exit_slow = !next_st.cfg.fast_exit; // [R11] [R12]
    // dll runs unless disabled, in self refresh, or frozen by slow exit
    next_st.dll_on = !next_st.cfg.dll_disable && !self_refresh // [R24] [R16]
                     && !(pd_precharge && !next_st.cfg.fast_exit); // [R11] [R12]
    next_st.dll_for_write = write_odt_en; // [R17]
    // read engine: wait full read latency, then stream eight beat slots
    unique case (st.rd_st)
      RD_IDLE: begin
        if (is_read) begin
          next_st.rd_st = RD_WAIT;
          next_st.rd_cnt = st.rl; // [R5] [R22]
          next_st.rd_start = cmd.addr[2:0]; // [R3]
          next_st.rd_beat = 3'h0;
          next_st.rd_chop = (st.cfg.burst_mode == BL_FIXED4) // [R26]
                            || (st.cfg.burst_mode == BL_OTF && !cmd.addr[OTF_BIT]);
        end
      end
      RD_WAIT: begin
        if (st.rd_cnt <= 6'h01) begin
          next_st.rd_st = RD_BURST;
        end else begin
          next_st.rd_cnt = st.rd_cnt - 6'h01;
        end
      end
      RD_BURST: begin
        if (push) begin
          next_st.rd_beat = st.rd_beat + 3'h1;
          if (st.rd_beat == LAST_BEAT) begin
            next_st.rd_st = RD_IDLE;
          end
        end
      end
      default: next_st.rd_st = RD_IDLE;
    endcase
    // two-entry buffer: pop shifts, push fills the first free slot
    if (pop) begin
      next_st.buf_q[0] = st.buf_q[1];
      cnt = cnt - 2'h1;
    end
    if (push) begin
      next_st.buf_q[cnt[0]] = new_beat;
      cnt = cnt + 2'h1;
    end
    next_st.buf_cnt = cnt;
    next_st.out_valid = (cnt != 2'h0);
    // write engine: fixed chop pulls the internal start in, on the fly does not
    if (!st.wr_busy && is_write) begin
      if (st.cfg.burst_mode == BL_FIXED4) begin
        wl_eff = st.wl - WR_PULL_IN; // [R1]
      end else begin
        wl_eff = st.wl; // [R2]
      end
      next_st.wr_busy = 1'b1;
      next_st.wr_cnt = (wl_eff == 6'h00 || wl_eff > st.wl) ? 6'h01 : wl_eff;
      next_st.wr_chop = (st.cfg.burst_mode == BL_FIXED4)
                        || (st.cfg.burst_mode == BL_OTF && !cmd.addr[OTF_BIT]);
    end else if (st.wr_busy) begin
      if (st.wr_cnt <= 6'h01) begin
        next_st.wr_busy = 1'b0;
        next_st.wr_start = 1'b1;
        next_st.wr_term_on = write_odt_en; // [R21]
      end else begin
        next_st.wr_cnt = st.wr_cnt - 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register; low clk_en freezes everything

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= ST_RESET;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // outputs are plain flop fields
  assign beat_valid = st.out_valid;
  assign beat = st.buf_q[0];
  assign wr_start = st.wr_start;
  assign wr_chop = st.wr_chop;
  assign wr_term_on = st.wr_term_on;
  assign cfg = st.cfg;
  assign read_lat = st.rl;
  assign write_lat = st.wl;
  assign dal_cyc = st.dal;
  assign dll_on = st.dll_on;
  assign dll_reset = st.dll_reset;
  assign pd_exit_slow = st.pd_exit_slow;
  assign dll_for_write = st.dll_for_write;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_mr0_load;
    clk_en && is_mrs && cmd.ba == BA_BURST |=> st.mr0 == $past(cmd.addr);
  endproperty
  a_mr0_load: assert property (p_mr0_load) else $error("burst register not loaded"); // [R27]

  property p_mr1_load;
    clk_en && is_mrs && cmd.ba == BA_DLL |=> st.mr1 == $past(cmd.addr) ##1
      (!clk_en || cfg.drv_imp == {st.mr1[DIC1_BIT], st.mr1[DIC0_BIT]});
  endproperty
  a_mr1_load: assert property (p_mr1_load) else $error("dll register not loaded"); // [R13]

  property p_dll_selfclear;
    clk_en && st.mr0[DLLRST_BIT] && !is_mrs |=> !st.mr0[DLLRST_BIT] && dll_reset;
  endproperty
  a_dll_selfclear: assert property (p_dll_selfclear) else $error("dll reset stuck"); // [R7]

  property p_dll_off;
    st.mr1[DLLDIS_BIT] |-> !dll_on;
  endproperty
  a_dll_off: assert property (p_dll_off) else $error("dll on while disabled"); // [R24]

  property p_chop_hiz;
    beat_valid && beat.chop && beat.idx[2] |-> beat.drive_n;
  endproperty
  a_chop_hiz: assert property (p_chop_hiz) else $error("chop beat driven"); // [R4]

  property p_pd_slow;
    clk_en && pd_precharge && !next_st.cfg.fast_exit |=> !dll_on && pd_exit_slow;
  endproperty
  a_pd_slow: assert property (p_pd_slow) else $error("dll running in slow exit"); // [R11]

  property p_sr_dll;
    clk_en && self_refresh |=> !dll_on;
  endproperty
  a_sr_dll: assert property (p_sr_dll) else $error("dll running in self refresh"); // [R16]

  property p_wr_pull;
    clk_en && !st.wr_busy && is_write && cfg.burst_mode == BL_FIXED4 && read_lat >= 6'h04
      && write_lat >= 6'h03 |=> st.wr_cnt == $past(write_lat) - 6'h02;
  endproperty
  a_wr_pull: assert property (p_wr_pull) else $error("fixed chop not pulled in"); // [R1]

  property p_wr_otf;
    clk_en && !st.wr_busy && is_write && cfg.burst_mode == BL_OTF && write_lat != 6'h00
      |=> st.wr_cnt == $past(write_lat);
  endproperty
  a_wr_otf: assert property (p_wr_otf) else $error("on the fly write pulled in"); // [R2]

  property p_rl_start;
    clk_en && st.rd_st == RD_IDLE && is_read |=> st.rd_cnt == $past(read_lat);
  endproperty
  a_rl_start: assert property (p_rl_start) else $error("read latency not loaded"); // [R5]

  // a stalled head beat must neither vanish nor change under the consumer
  property p_beat_hold;
    beat_valid && !beat_ready |=> beat_valid && $stable(beat);
  endproperty
  a_beat_hold: assert property (p_beat_hold) else $error("stalled beat changed"); // [R3]

  property p_wr_term;
    wr_term_on |-> wr_start;
  endproperty
  a_wr_term: assert property (p_wr_term) else $error("stray write term"); // [R21]

  property p_otf_chop;
    clk_en && !st.wr_busy && is_write && cfg.burst_mode == BL_OTF
      |=> wr_chop == !$past(cmd.addr[OTF_BIT]);
  endproperty
  a_otf_chop: assert property (p_otf_chop) else $error("chop select lost"); // [R2]

  property p_rl_sum;
    read_lat == {1'b0, cfg.add_lat} + {1'b0, cfg.cas_lat};
  endproperty
  a_rl_sum: assert property (p_rl_sum) else $error("read latency sum"); // [R5]

  c_read_burst: cover property (st.rd_st == RD_BURST && push && st.rd_beat == LAST_BEAT);
  c_buf_full: cover property (st.buf_cnt == 2'h2 && !beat_ready);
  c_wr_start: cover property (wr_start && wr_chop);
  c_dll_reset: cover property (dll_reset);

endmodule

//--- sim/smd_ctrl_model.sv
// Purpose: controller model that puts mode register sets, reads and writes on the pins
// Assumes: the bench raises req_go for one cycle from a falling edge
// Notes: while deselected, the other pins show the inverse of the last value
`timescale 1ns/1ps

module smd_ctrl_model
  import smd_pkg::*;
#(
  // smallest recovery the controller may program, in cycles; plain default
  parameter logic [4:0] WR_MIN = 5'h05
)
(
  // request from the bench
  input wire logic req_go,
  input wire logic [2:0] req_code,
  input wire logic [2:0] req_ba,
  input wire logic [AW-1:0] req_addr,
  // command pins toward the device
  output smd_cmd_t cmd
);
  ////////////////////////////////////////////////////////////////////////////////
  // a deselect must not leave a stale command readable on the pins
  always_comb begin
    cmd.cs_n = ~req_go;
    {cmd.ras_n, cmd.cas_n, cmd.we_n} = req_go ? req_code : ~req_code;
    cmd.ba = req_go ? req_ba : ~req_ba;
    cmd.addr = req_go ? req_addr : ~req_addr;
    if (req_go && req_code == CMD_MRS && req_ba == BA_BURST) begin
      cmd.addr[TM_BIT] = 1'b0;
      // a too short recovery is raised to the longest code rather than sent
      if (WR_CYC[req_addr[WR_LSB+2:WR_LSB]] < WR_MIN) begin
        cmd.addr[WR_LSB+2:WR_LSB] = 3'h0;
      end
    end
    if (req_go && req_code == CMD_MRS && req_ba == BA_DLL) begin
      cmd.ba[2] = 1'b0;
      cmd.addr[8] = 1'b0;
      cmd.addr[10] = 1'b0;
      cmd.addr[11] = 1'b0;
      // dll off: nominal termination is never programmed on
      if (req_addr[DLLDIS_BIT]) begin
        cmd.addr[RTT0_BIT] = 1'b0;
        cmd.addr[RTT1_BIT] = 1'b0;
        cmd.addr[RTT2_BIT] = 1'b0;
      end
      // write leveling only with outputs off; the termination code is sent as requested, unchecked
      if (!req_addr[QOFF_BIT]) begin
        cmd.addr[WLEV_BIT] = 1'b0;
      end
    end
  end
endmodule

//--- sim/smd_mode_decode_tb.sv
// Purpose: self-checking bench for the mode register decoder
// Assumes: write column latency 5 and precharge time 6 cycles throughout
// Notes: inputs change on the falling edge; read beats stall every other cycle
`timescale 1ns/1ps

module smd_mode_decode_tb;
  import smd_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic self_refresh = 1'b0;
  logic pd_precharge = 1'b0;
  logic write_odt_en = 1'b0;
  logic beat_ready = 1'b0;
  logic req_go = 1'b0;
  logic [2:0] req_code = CMD_MRS;
  logic [2:0] req_ba = BA_BURST;
  logic [AW-1:0] req_addr = 13'h0000;
  smd_cmd_t cmd;
  smd_beat_t beat;
  smd_cfg_t cfg;
  logic beat_valid, wr_start, wr_chop, wr_term_on, dll_on, dll_reset, pd_exit_slow, dll_for_write;
  logic [5:0] read_lat, write_lat, dal_cyc;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  localparam int dll_lock_time = 16; // arbitrary lock wait in cycles

  ////////////////////////////////////////////////////////////////////////////////
  // clock, and a ceiling far above the few hundred cycles the tests need
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  smd_ctrl_model ctrl (.req_go(req_go), .req_code(req_code), .req_ba(req_ba),
    .req_addr(req_addr), .cmd(cmd));

  smd_mode_decode DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .cmd(cmd),
    .self_refresh(self_refresh), .pd_precharge(pd_precharge), .write_odt_en(write_odt_en),
    .write_col_lat(5'h05), .trp_cyc(5'h06), .beat_valid(beat_valid), .beat(beat),
    .beat_ready(beat_ready), .wr_start(wr_start), .wr_chop(wr_chop), .wr_term_on(wr_term_on),
    .cfg(cfg), .read_lat(read_lat), .write_lat(write_lat), .dal_cyc(dal_cyc), .dll_on(dll_on),
    .dll_reset(dll_reset), .pd_exit_slow(pd_exit_slow), .dll_for_write(dll_for_write));

  ////////////////////////////////////////////////////////////////////////////////
  // shared compare and command tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic issue(input logic [2:0] code, input logic [2:0] ba, input logic [AW-1:0] a);
    @(negedge clk_sys);
    req_code = code;
    req_ba = ba;
    req_addr = a;
    req_go = 1'b1;
    @(negedge clk_sys);
    req_go = 1'b0;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // field decode: cl 6, recovery 7, fast exit, interleaved, all additive codes
  task automatic t_regs();
    logic [4:0] ale [4] = '{5'h00, 5'h05, 5'h04, 5'h00};
    issue(CMD_MRS, BA_BURST, 13'h1628);
    check(cfg.cas_lat, 5'h06);
    check(cfg.wr_rec, 5'h07);
    check(dal_cyc, 6'h0D);
    check(cfg.interleave, 1'b1);
    check(pd_exit_slow, 1'b0);
    for (int k = 0; k < 4; k++) begin
      issue(CMD_MRS, BA_DLL, 13'h0022 | 13'(k << 3));
      check(cfg.add_lat, ale[k]);
      check(read_lat, ale[k] + 6);
      check(write_lat, ale[k] + 5);
      check(cfg.drv_imp, 2'h3);
    end
    issue(CMD_MRS, BA_DLL, 13'h1284);
    check(cfg.rtt_nom, 3'h5);
    check(cfg.wlevel, 1'b1);
    check(cfg.out_disable, 1'b1);
    check(cfg.drv_imp, 2'h0);
    issue(CMD_MRS, BA_DLL, 13'h002A);
    // with the enable low a register set must leave every setting alone
    clk_en = 1'b0;
    issue(CMD_MRS, BA_BURST, 13'h0000);
    check(cfg.cas_lat, 5'h06);
    check(read_lat, 6'h0B);
    clk_en = 1'b1;
    $display("test regs done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // dll reset pulse and the dll enable conditions
  task automatic t_dll();
    int p = 0;
    issue(CMD_MRS, BA_BURST, 13'h1728);
    repeat (6) begin
      @(negedge clk_sys);
      p += (dll_reset === 1'b1);
    end
    check(p, 1);
    // no dll-dependent command until the lock time has run, enable held high
    repeat (dll_lock_time) @(negedge clk_sys);
    check(dll_on, 1'b1);
    self_refresh = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(dll_on, 1'b0);
    self_refresh = 1'b0;
    pd_precharge = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(dll_on, 1'b1);
    issue(CMD_MRS, BA_BURST, 13'h0628);
    @(negedge clk_sys);
    check(pd_exit_slow, 1'b1);
    check(dll_on, 1'b0);
    pd_precharge = 1'b0;
    write_odt_en = 1'b0; // no write termination while the dll is off
    issue(CMD_MRS, BA_DLL, 13'h002B);
    @(negedge clk_sys);
    check(dll_on, 1'b0);
    issue(CMD_MRS, BA_DLL, 13'h002A);
    @(negedge clk_sys);
    check(dll_on, 1'b1);
    $display("test dll done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // one read of eight slots; the consumer stalls so the buffer must hold beats
  task automatic rd(input logic [2:0] s, input logic chop, input logic inter, input logic off);
    int n = 0;
    int i = 0;
    logic [2:0] c;
    issue(CMD_READ, 3'h0, {~chop, 9'h000, s});
    while (beat_valid !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    check(n, 12);
    while (i < 8 && n < 200) begin
      @(negedge clk_sys);
      beat_ready = ~beat_ready;
      n++;
      if (beat_valid === 1'b1 && beat_ready) begin
        c = inter ? s ^ i[2:0] : {s[2] ^ i[2], s[1:0] + i[1:0]};
        check(beat, {c, i[2:0], chop, off | (chop & i[2])});
        i++;
      end
    end
    check(i, 8);
    // let the edge that takes the last beat pass before the consumer stops
    @(negedge clk_sys);
    check(beat_valid, 1'b0);
    beat_ready = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // write start delay for each burst length mode, with write termination on or off
  task automatic wr(input logic [AW-1:0] mode, input logic chop, input int exp_n,
    input logic odt);
    int n = 0;
    issue(CMD_MRS, BA_BURST, mode);
    write_odt_en = odt;
    issue(CMD_WRITE, 3'h0, {~chop, 12'h000});
    while (wr_start !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    check(n, exp_n);
    check(wr_chop, chop);
    check(wr_term_on, odt);
    check(dll_for_write, odt);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    check(cfg.wr_rec, 5'h10);
    check(beat_valid, 1'b0);
    t_regs();
    t_dll();
    issue(CMD_MRS, BA_BURST, 13'h1628);
    rd(3'h5, 1'b0, 1'b1, 1'b0);
    issue(CMD_MRS, BA_BURST, 13'h1621);
    rd(3'h6, 1'b1, 1'b0, 1'b0);
    rd(3'h3, 1'b0, 1'b0, 1'b0);
    issue(CMD_MRS, BA_DLL, 13'h102A);
    rd(3'h2, 1'b0, 1'b0, 1'b1);
    issue(CMD_MRS, BA_DLL, 13'h002A);
    $display("test read done");
    wr(13'h1622, 1'b1, 8, 1'b1);
    wr(13'h1621, 1'b1, 10, 1'b1);
    wr(13'h1628, 1'b0, 10, 1'b0);
    $display("test write done");
    results();
  end
endmodule
